/* rtl/ctsio_map.vh */
// ctsio_map.vh: register map, field positions, reset values and timing counts
// for the trigger/strobe/packet pacing block; included by ctsio_top.v only.
`ifndef CTSIO_MAP_VH
`define CTSIO_MAP_VH

// clock and time units
`define CTSIO_CLK_PERIOD_NS 8
`define CTSIO_US_IN_NS 1000
`define CTSIO_CYC_PER_US (`CTSIO_US_IN_NS / `CTSIO_CLK_PERIOD_NS)
`define CTSIO_NS_PER_CYC 33'h000000008

// register offsets (byte addresses)
`define CTSIO_OFS_CTRL 8'h00
`define CTSIO_OFS_TRIG_DELAY 8'h04
`define CTSIO_OFS_DEBOUNCE 8'h08
`define CTSIO_OFS_STB_DELAY 8'h0C
`define CTSIO_OFS_STB_WIDTH 8'h10
`define CTSIO_OFS_PKT_GAP 8'h14
`define CTSIO_OFS_TX_DELAY 8'h18
`define CTSIO_OFS_STATUS 8'h1C

// control fields
`define CTSIO_CTRL_TRIG_POL 0
`define CTSIO_CTRL_OUT_POL 1
`define CTSIO_CTRL_OUT_SRC 2
`define CTSIO_CTRL_DEV_RESET 3

// status fields
`define CTSIO_STAT_TRIG_LVL 0
`define CTSIO_STAT_OUT_LVL 1
`define CTSIO_STAT_READY 2
`define CTSIO_STAT_EXPOSING 3
`define CTSIO_STAT_STROBE 4

// factory defaults
`define CTSIO_RST_TRIG_POL 1'b1
`define CTSIO_RST_OUT_POL 1'b1
`define CTSIO_RST_OUT_SRC 1'b0
`define CTSIO_RST_TRIG_DELAY 32'h00000000
`define CTSIO_RST_DEBOUNCE 32'h00000001
`define CTSIO_RST_STB_DELAY 32'h00000000
`define CTSIO_RST_STB_WIDTH 32'h00000001
`define CTSIO_RST_PKT_GAP 32'h00001770
`define CTSIO_RST_TX_DELAY 32'h00000000

// setting ceilings in microseconds
`define CTSIO_MAX_TRIG_DELAY 32'h01312D00
`define CTSIO_MAX_DEBOUNCE 32'h00002710
`define CTSIO_MAX_STB 32'h00FFFFFF

`endif

/* rtl/ctsio_top.v */
// ctsio_top.v: trigger input conditioning, exposure start delay, output line
// (ready indicator or strobe timer) and packet transmit pacing.
// assumes one 125 MHz clock; the trigger pin is asynchronous, all other
// inputs come from logic on clk_in.
//
// Notes on behaviour
// - exposure starts a set 0..20000000 us after trigger recognition, default 0.
// - trigger input polarity selectable, true means positive, default true.
// - output line polarity inverted through its own polarity setting.
// - trigger recognised after pulse held 0..10000 us, default 1; source holds it.
// - ready-indicator source drives output ON while a trigger can be accepted.
// - strobe source drives output with a timer-generated strobe pulse.
// - trigger line level readable as status, true is ON; output line status bit is its pin level.
// - strobe waits 0..16777215 us, default 0, only in strobe mode.
// - strobe pulse held 0..16777215 us, default 1, in strobe mode.
// - gap between image packets 0..4294967295 ns, default 6000.
// - packet transmission start delayed 0..4294967295 ns, default 0.
// - device reset command restores every setting to its factory default.
`timescale 1ns/1ps
`default_nettype none
`include "ctsio_map.vh"

module ctsio_top (
  input wire clk_in,
  input wire reset_n_in,
  input wire [7:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output reg [31:0] rd_data_out,
  input wire trig_pin_in,
  input wire exposure_done_in,
  output reg exposure_start_out,
  output reg out_line_out,
  input wire frame_start_in,
  input wire frame_end_in,
  input wire pkt_pending_in,
  output reg pkt_send_out
);

  localparam [1:0] T_IDLE = 2'h0;
  localparam [1:0] T_DELAY = 2'h1;
  localparam [1:0] T_EXPOSE = 2'h2;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_DELAY = 2'h1;
  localparam [1:0] S_PULSE = 2'h2;

  reg trig_pol_q;
  reg out_pol_q;
  reg out_src_q;
  reg [31:0] trig_delay_q;
  reg [31:0] debounce_q;
  reg [31:0] stb_delay_q;
  reg [31:0] stb_width_q;
  reg [31:0] pkt_gap_q;
  reg [31:0] tx_delay_q;

  reg trig_meta_q;
  reg trig_sync_q;
  reg [31:0] deb_cnt_q;
  reg deb_done_q;
  reg [1:0] tstate_q;
  reg [31:0] tcnt_q;
  reg [1:0] sstate_q;
  reg [31:0] scnt_q;
  reg strobe_q;
  reg frame_act_q;
  reg first_pkt_q;
  reg [32:0] pkt_ns_q;

  wire trig_active;
  wire ready;
  wire out_raw;
  wire [31:0] deb_cyc;
  wire [31:0] tdly_cyc;
  wire [31:0] sdly_cyc;
  wire [31:0] swid_cyc;
  wire [32:0] pkt_tgt;
  wire trig_hit;
  wire stb_mode;
  wire dev_reset;
  wire [31:0] wclamp_trig;
  wire [31:0] wclamp_deb;
  wire [31:0] wclamp_stb;

  assign trig_active = trig_sync_q ^ ~trig_pol_q;
  assign ready = (tstate_q == T_IDLE);
  assign stb_mode = out_src_q;
  assign out_raw = stb_mode ? strobe_q : ready;

  // microsecond settings become cycle counts; products stay below 2^32
  assign deb_cyc = debounce_q * `CTSIO_CYC_PER_US;
  assign tdly_cyc = trig_delay_q * `CTSIO_CYC_PER_US;
  assign sdly_cyc = stb_delay_q * `CTSIO_CYC_PER_US;
  assign swid_cyc = stb_width_q * `CTSIO_CYC_PER_US;

  // writes above range saturate rather than wrap into a short time
  assign wclamp_trig = (wr_data_in > `CTSIO_MAX_TRIG_DELAY) ?
                       `CTSIO_MAX_TRIG_DELAY : wr_data_in;
  assign wclamp_deb = (wr_data_in > `CTSIO_MAX_DEBOUNCE) ?
                      `CTSIO_MAX_DEBOUNCE : wr_data_in;
  assign wclamp_stb = (wr_data_in > `CTSIO_MAX_STB) ? `CTSIO_MAX_STB : wr_data_in;

  assign dev_reset = wr_en_in && (addr_in == `CTSIO_OFS_CTRL) &&
                     wr_data_in[`CTSIO_CTRL_DEV_RESET];

  // settings registers
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig_pol_q <= `CTSIO_RST_TRIG_POL;
      out_pol_q <= `CTSIO_RST_OUT_POL;
      out_src_q <= `CTSIO_RST_OUT_SRC;
      trig_delay_q <= `CTSIO_RST_TRIG_DELAY;
      debounce_q <= `CTSIO_RST_DEBOUNCE;
      stb_delay_q <= `CTSIO_RST_STB_DELAY;
      stb_width_q <= `CTSIO_RST_STB_WIDTH;
      pkt_gap_q <= `CTSIO_RST_PKT_GAP;
      tx_delay_q <= `CTSIO_RST_TX_DELAY;
    end else if (dev_reset) begin
      trig_pol_q <= `CTSIO_RST_TRIG_POL;
      out_pol_q <= `CTSIO_RST_OUT_POL;
      out_src_q <= `CTSIO_RST_OUT_SRC;
      trig_delay_q <= `CTSIO_RST_TRIG_DELAY;
      debounce_q <= `CTSIO_RST_DEBOUNCE;
      stb_delay_q <= `CTSIO_RST_STB_DELAY;
      stb_width_q <= `CTSIO_RST_STB_WIDTH;
      pkt_gap_q <= `CTSIO_RST_PKT_GAP;
      tx_delay_q <= `CTSIO_RST_TX_DELAY;
    end else if (wr_en_in) begin
      case (addr_in)
        `CTSIO_OFS_CTRL: begin
          trig_pol_q <= wr_data_in[`CTSIO_CTRL_TRIG_POL];
          out_pol_q <= wr_data_in[`CTSIO_CTRL_OUT_POL];
          out_src_q <= wr_data_in[`CTSIO_CTRL_OUT_SRC];
        end
        `CTSIO_OFS_TRIG_DELAY: trig_delay_q <= wclamp_trig;
        `CTSIO_OFS_DEBOUNCE: debounce_q <= wclamp_deb;
        `CTSIO_OFS_STB_DELAY: stb_delay_q <= wclamp_stb;
        `CTSIO_OFS_STB_WIDTH: stb_width_q <= wclamp_stb;
        `CTSIO_OFS_PKT_GAP: pkt_gap_q <= wr_data_in;
        `CTSIO_OFS_TX_DELAY: tx_delay_q <= wr_data_in;
        default: begin
        end
      endcase
    end
  end

  // read port, data in the cycle after the strobe only
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 32'h00000000;
    end else if (rd_en_in) begin
      case (addr_in)
        `CTSIO_OFS_CTRL: begin
          rd_data_out <= 32'h00000000;
          rd_data_out[`CTSIO_CTRL_TRIG_POL] <= trig_pol_q;
          rd_data_out[`CTSIO_CTRL_OUT_POL] <= out_pol_q;
          rd_data_out[`CTSIO_CTRL_OUT_SRC] <= out_src_q;
        end
        `CTSIO_OFS_TRIG_DELAY: rd_data_out <= trig_delay_q;
        `CTSIO_OFS_DEBOUNCE: rd_data_out <= debounce_q;
        `CTSIO_OFS_STB_DELAY: rd_data_out <= stb_delay_q;
        `CTSIO_OFS_STB_WIDTH: rd_data_out <= stb_width_q;
        `CTSIO_OFS_PKT_GAP: rd_data_out <= pkt_gap_q;
        `CTSIO_OFS_TX_DELAY: rd_data_out <= tx_delay_q;
        `CTSIO_OFS_STATUS: begin
          rd_data_out <= 32'h00000000;
          rd_data_out[`CTSIO_STAT_TRIG_LVL] <= trig_active;
          rd_data_out[`CTSIO_STAT_OUT_LVL] <= out_line_out;
          rd_data_out[`CTSIO_STAT_READY] <= ready;
          rd_data_out[`CTSIO_STAT_EXPOSING] <= (tstate_q == T_EXPOSE);
          rd_data_out[`CTSIO_STAT_STROBE] <= strobe_q;
        end
        default: rd_data_out <= 32'h00000000;
      endcase
    end else begin
      rd_data_out <= 32'h00000000;
    end
  end

  // trigger pin synchroniser
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
    end else begin
      trig_meta_q <= trig_pin_in;
      trig_sync_q <= trig_meta_q;
    end
  end

  // pulse width qualification
  // one recognition per pulse; the line must go inactive before the next
  assign trig_hit = trig_active && !deb_done_q && (deb_cnt_q >= deb_cyc);

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      deb_cnt_q <= 32'h00000000;
      deb_done_q <= 1'b0;
    end else if (!trig_active) begin
      deb_cnt_q <= 32'h00000000;
      deb_done_q <= 1'b0;
    end else if (trig_hit) begin
      deb_done_q <= 1'b1;
    end else if (!deb_done_q) begin
      // frozen after recognition, so a long pulse cannot wrap the count
      deb_cnt_q <= deb_cnt_q + 32'h00000001;
    end
  end

  // trigger to exposure sequencer; triggers outside idle are dropped
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tstate_q <= T_IDLE;
      tcnt_q <= 32'h00000000;
      exposure_start_out <= 1'b0;
    end else begin
      exposure_start_out <= 1'b0;
      case (tstate_q)
        T_IDLE: begin
          tcnt_q <= 32'h00000000;
          if (trig_hit) begin
            tstate_q <= T_DELAY;
          end
        end
        T_DELAY: begin
          if (tcnt_q >= tdly_cyc) begin
            tstate_q <= T_EXPOSE;
            exposure_start_out <= 1'b1;
          end else begin
            tcnt_q <= tcnt_q + 32'h00000001;
          end
        end
        T_EXPOSE: begin
          if (exposure_done_in) begin
            tstate_q <= T_IDLE;
          end
        end
        default: tstate_q <= T_IDLE;
      endcase
    end
  end

  // strobe timer
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sstate_q <= S_IDLE;
      scnt_q <= 32'h00000000;
      strobe_q <= 1'b0;
    end else begin
      case (sstate_q)
        S_IDLE: begin
          scnt_q <= 32'h00000000;
          strobe_q <= 1'b0;
          if (exposure_start_out && stb_mode) begin
            sstate_q <= S_DELAY;
          end
        end
        S_DELAY: begin
          if (scnt_q >= sdly_cyc) begin
            scnt_q <= 32'h00000000;
            // width 0 keeps the line quiet instead of a one-cycle glitch
            if (swid_cyc != 32'h00000000) begin
              sstate_q <= S_PULSE;
              strobe_q <= 1'b1;
            end else begin
              sstate_q <= S_IDLE;
            end
          end else begin
            scnt_q <= scnt_q + 32'h00000001;
          end
        end
        S_PULSE: begin
          if (scnt_q >= swid_cyc - 32'h00000001) begin
            sstate_q <= S_IDLE;
            strobe_q <= 1'b0;
          end else begin
            scnt_q <= scnt_q + 32'h00000001;
          end
        end
        default: begin
          sstate_q <= S_IDLE;
          strobe_q <= 1'b0;
        end
      endcase
    end
  end

  // output line register
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_line_out <= 1'b0;
    end else begin
      out_line_out <= out_raw ^ ~out_pol_q;
    end
  end

  // packet pacing: first packet waits the start delay, later ones the gap
  assign pkt_tgt = first_pkt_q ? {1'b0, tx_delay_q} : {1'b0, pkt_gap_q};

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_act_q <= 1'b0;
      first_pkt_q <= 1'b1;
      pkt_ns_q <= 33'h000000000;
      pkt_send_out <= 1'b0;
    end else begin
      pkt_send_out <= 1'b0;
      if (frame_start_in) begin
        frame_act_q <= 1'b1;
        first_pkt_q <= 1'b1;
        pkt_ns_q <= 33'h000000000;
      end else if (frame_end_in) begin
        frame_act_q <= 1'b0;
      end else if (frame_act_q) begin
        if ((pkt_ns_q >= pkt_tgt) && pkt_pending_in && !pkt_send_out) begin
          pkt_send_out <= 1'b1;
          first_pkt_q <= 1'b0;
          pkt_ns_q <= 33'h000000000;
        end else if (pkt_ns_q < pkt_tgt) begin
          // stops at the target, so a long wait for data cannot overflow
          pkt_ns_q <= pkt_ns_q + `CTSIO_NS_PER_CYC;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* test/ctsio_properties.sv */
// port checker for ctsio_top, attached by bind
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module ctsio_properties (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [31:0] rd_data_out,
  input wire logic trig_pin_in,
  input wire logic exposure_done_in,
  input wire logic exposure_start_out,
  input wire logic out_line_out,
  input wire logic frame_start_in,
  input wire logic frame_end_in,
  input wire logic pkt_pending_in,
  input wire logic pkt_send_out
);
  // shadow of control: [0] trigger pol, [1] output pol, [2] source
  logic [2:0] ctl_q;
  logic frm_q;
  logic exp_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_q <= 3'h3;
      frm_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      if (wr_en_in && addr_in == 8'h00) ctl_q <= wr_data_in[3] ? 3'h3 : wr_data_in[2:0];
      if (frame_start_in) frm_q <= 1'b1;
      else if (frame_end_in) frm_q <= 1'b0;
      if (exposure_start_out) exp_q <= 1'b1;
      else if (exposure_done_in) exp_q <= 1'b0;
    end
  end
  AST_RD_IDLE: assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
    else $error("read data not zero outside read slot");
  AST_RD_UNMAPPED: assert property (rd_en_in && addr_in == 8'h20 |=> rd_data_out == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_RD: assert property (rd_en_in && addr_in == 8'h00 |=> rd_data_out[3:0] == {1'b0, ctl_q})
    else $error("control readback wrong");
  AST_STATUS_OUT: assert property (rd_en_in && addr_in == 8'h1C && $stable(out_line_out)
    ##1 $stable(out_line_out) |-> rd_data_out[1] == out_line_out)
    else $error("status output level wrong");
  AST_READY_DROP: assert property (ctl_q[2:1] == 2'b01 && exposure_start_out |=> !out_line_out)
    else $error("ready line still on during exposure");
  AST_READY_INV: assert property (ctl_q[2:1] == 2'b00 && exposure_start_out |=> out_line_out)
    else $error("inverted ready line wrong");
  AST_START_ONCE: assert property (exposure_start_out |-> !exp_q)
    else $error("exposure start while exposing");
  AST_START_PULSE: assert property (exposure_start_out |=> !exposure_start_out)
    else $error("exposure start longer than one cycle");
  AST_PKT_SPACE: assert property (pkt_send_out |=> !pkt_send_out)
    else $error("packet grants back to back");
  AST_PKT_FRAME: assert property (!frm_q && !$past(frm_q) |-> !pkt_send_out)
    else $error("packet grant outside frame");
endmodule
bind ctsio_top ctsio_properties u_props (.clk_in, .reset_n_in, .addr_in, .wr_data_in,
  .wr_en_in, .rd_en_in, .rd_data_out, .trig_pin_in, .exposure_done_in, .exposure_start_out,
  .out_line_out, .frame_start_in, .frame_end_in, .pkt_pending_in, .pkt_send_out);
`default_nettype wire

/* test/ctsio_trig_src.sv */
// trigger source model driving the camera input line
// assumes requests arrive on clk_in from the bench
`timescale 1ns/1ps
`default_nettype none
module ctsio_trig_src (
  input wire logic clk_in,
  input wire logic fire_in,
  input wire logic [15:0] len_in,
  input wire logic act_in,
  output logic pin_out
);
  logic [15:0] cnt_q = 16'h0000;
  // pulse held for the full width
  always @(posedge clk_in) begin
    if (fire_in) cnt_q <= len_in;
    else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
  end
  // idle level is the inverse of the active one
  assign pin_out = (cnt_q != 16'h0000) ? act_in : !act_in;
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for ctsio_top with a trigger source model
// assumes a 125 MHz clock; long counts are set small through registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_en_in = 1'b0, rd_en_in = 1'b0, exposure_done_in = 1'b0;
  logic frame_start_in = 1'b0, frame_end_in = 1'b0, pkt_pending_in = 1'b0;
  logic fire = 1'b0, act = 1'b1;
  logic [15:0] plen = 16'h0001;
  logic trig_pin_in, exposure_start_out, out_line_out, pkt_send_out;
  logic [31:0] rd_data_out;
  logic [31:0] dflt [0:6] = '{32'h3, 32'h0, 32'h1, 32'h0, 32'h1, 32'h1770, 32'h0};
  int bad_count = 0;
  int check_count = 0;
  int n;
  ctsio_top dut (.clk_in, .reset_n_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .rd_data_out, .trig_pin_in, .exposure_done_in, .exposure_start_out, .out_line_out,
    .frame_start_in, .frame_end_in, .pkt_pending_in, .pkt_send_out);
  ctsio_trig_src src (.clk_in, .fire_in(fire), .len_in(plen), .act_in(act), .pin_out(trig_pin_in));
  initial forever #4 clk_in = ~clk_in;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // data is looked at once, in the single cycle it stands
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 check(rd_data_out, exp);
    @(posedge clk_in);
  endtask
  // counts falling edges until the chosen output reaches lvl
  task automatic wait_for(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_in);
      cnt++;
    end while ((sel == 0 ? exposure_start_out : sel == 1 ? out_line_out : pkt_send_out) !== lvl
      && cnt < 4000);
    @(posedge clk_in);
    if (cnt >= 4000) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic pulse(input logic [15:0] len);
    plen <= len;
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
  endtask
  task automatic end_exposure;
    exposure_done_in <= 1'b1;
    @(posedge clk_in);
    exposure_done_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 7; i++) rd(8'(4 * i), dflt[i]);
    rd(8'h20, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h6);
    wr(8'h08, 32'h0);
    pulse(16'h0002);
    wait_for(0, 1'b1, n);
    near(n, 4, 7);
    rd(8'h1C, 32'h8);
    end_exposure();
    rd(8'h1C, 32'h6);
    wr(8'h08, 32'h1);
    wr(8'h04, 32'h1);
    pulse(16'h00C8);
    wait_for(0, 1'b1, n);
    near(n, 254, 257);
    end_exposure();
    // a pulse shorter than the debounce width must be ignored
    pulse(16'h0064);
    n = 0;
    repeat (300) begin
      @(negedge clk_in);
      if (exposure_start_out !== 1'b0) n++;
    end
    @(posedge clk_in);
    check(32'(n), 32'h0);
    wr(8'h00, 32'h0);
    act <= 1'b0;
    repeat (4) @(posedge clk_in);
    rd(8'h1C, 32'h4);
    pulse(16'h00C8);
    wait_for(0, 1'b1, n);
    near(n, 254, 257);
    rd(8'h1C, 32'hA);
    end_exposure();
    wr(8'h00, 32'h7);
    act <= 1'b1;
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h1);
    wr(8'h10, 32'h2);
    repeat (4) @(posedge clk_in);
    pulse(16'h00C8);
    wait_for(0, 1'b1, n);
    wait_for(1, 1'b1, n);
    near(n, 125, 129);
    wait_for(1, 1'b0, n);
    check(32'(n), 32'hFA);
    end_exposure();
    // out-of-range writes saturate at the top of each range
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h01312D00);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h00002710);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h00FFFFFF);
    wr(8'h00, 32'h8);
    for (int i = 0; i < 7; i++) rd(8'(4 * i), dflt[i]);
    wr(8'h18, 32'h50);
    wr(8'h14, 32'hA0);
    pkt_pending_in <= 1'b1;
    frame_start_in <= 1'b1;
    @(posedge clk_in);
    frame_start_in <= 1'b0;
    wait_for(2, 1'b1, n);
    near(n, 11, 14);
    wait_for(2, 1'b1, n);
    near(n, 19, 23);
    frame_end_in <= 1'b1;
    pkt_pending_in <= 1'b0;
    @(posedge clk_in);
    frame_end_in <= 1'b0;
    repeat (40) @(posedge clk_in);
    finish_test();
  end
endmodule
`default_nettype wire
